// ==== hw/fss_pkg.sv ====
// Constants and types shared by the fail-state supply supervisor.
// What this block does
// RULE1 - Stay-powered variant keeps MCU supply on after failure until recovery.
// RULE2 - Cut-off variants watch bus idle and/or sense input, then cut MCU supply.
// RULE3 - Strap code is sampled at init-to-normal and selects variant unless overridden.
// RULE4 - SPI code 111/110/101/100 overrides strap: stay, idle, input, combined.
// RULE5 - Strap below 6 k stay, below 24 k idle, below 50 k input, 50 k and above combined.
// RULE6 - Idle variant cuts supply 8 s after bus idle detected.
// RULE7 - Input variant cuts supply on high-to-low transition and low sense input.
// RULE8 - Combined variant cuts supply only when idle timeout and low input both seen.
// RULE9 - Wake-up in supply-off fail state enters reset mode; input wake must be pre-armed.
// RULE10 - Bus activity, LIN activity or armed high sense input are wake-up events.
// RULE11 - Fail indicator holds until flags cleared, then released by DD00 or DD80.
// RULE12 - Recovery needs reset low cleared, supply low cleared and a good refresh.
// RULE13 - Eight consecutive missed watchdog windows declare a persistent failure.
// RULE14 - Without refresh a 1 ms reset pulse is emitted every 256 ms.
// RULE15 - Watchdog failure asserts indicator at first or second pulse, by select bit.
// RULE16 - Supply below reset threshold drives indicator low with the reset output.
// RULE17 - Reset pin clamped low externally enters the fail state.
// RULE18 - Bus activity restarts the idle timer, so it needs 8 s of silence.
`default_nettype none
package fss_pkg;
  localparam int CLK_HZ          = 10_000_000;
  localparam int WD_WINDOW_MS    = 256;
  localparam int RST_PULSE_US    = 1000;
  localparam int IDLE_TIMEOUT_MS = 8000;
  localparam int CLAMP_MS        = 10;
  localparam int WD_WINDOW_CYC   = WD_WINDOW_MS * (CLK_HZ / 1000);
  localparam int RST_PULSE_CYC   = RST_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int IDLE_CYC        = IDLE_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int CLAMP_CYC       = CLAMP_MS * (CLK_HZ / 1000);
  localparam logic [3:0] WD_FAIL_LIMIT = 4'h8;
  localparam logic [7:0] STRAP_STAY_MAX_K  = 8'h06;
  localparam logic [7:0] STRAP_IDLE_MAX_K  = 8'h18;
  localparam logic [7:0] STRAP_INPUT_MAX_K = 8'h32;
  localparam logic [15:0] REL_CMD_A = 16'hDD00;
  localparam logic [15:0] REL_CMD_B = 16'hDD80;
  localparam int OVR_VALID_BIT = 2;

  typedef enum logic [1:0] {
    STAY_POWERED    = 2'h0,
    IDLE_CUTOFF     = 2'h1,
    INPUT_CUTOFF    = 2'h2,
    COMBINED_CUTOFF = 2'h3
  } fss_variant_type;

  typedef enum logic [2:0] {
    ST_NORMAL   = 3'h1,
    ST_FAIL_ON  = 3'h2,
    ST_FAIL_OFF = 3'h4
  } fss_state_type;
endpackage : fss_pkg
`default_nettype wire

// ==== hw/fss_timer.sv ====
// Restartable cycle timer with a sticky expiry flag.
`default_nettype none
module fss_timer #(
  parameter int CYCLES = 16,
  parameter int W      = $clog2(CYCLES + 1)
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic run,
  input  wire logic restart,
  output logic      expired
);
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic         expired_q;
  logic         expired_d;
  logic         atEnd;

  assign atEnd     = count_q == W'(CYCLES - 1);
  assign count_d   = (!run || restart) ? '0 : (expired_q ? count_q : count_q + W'(1));
  assign expired_d = run && !restart && (expired_q || atEnd);
  assign expired   = expired_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q   <= '0;
      expired_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      expired_q <= expired_d;
    end
  end
endmodule : fss_timer
`default_nettype wire

// ==== hw/fss_supervisor.sv ====
// Fail-state supervisor: watchdog, supply and reset-clamp failures, variant and supply cut-off.
`default_nettype none
module fss_supervisor #(
  parameter int WD_CYC    = fss_pkg::WD_WINDOW_CYC,
  parameter int PULSE_CYC = fss_pkg::RST_PULSE_CYC,
  parameter int IDLE_CY   = fss_pkg::IDLE_CYC,
  parameter int CLAMP_CY  = fss_pkg::CLAMP_CYC
) (
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  input  wire logic [7:0]               strapResistorPin,
  input  wire logic                     initToNormal,
  input  wire logic                     spiVariantWrite,
  input  wire logic [2:0]               spiVariantCode,
  input  wire logic                     spiCmdValid,
  input  wire logic [15:0]              spiCmd,
  input  wire logic                     mcuFlagsCleared,
  input  wire logic                     wdRefreshOk,
  input  wire logic                     wdSecondPulseSel,
  input  wire logic                     supplyLow,
  input  wire logic                     resetPinLow,
  input  wire logic                     canActivity,
  input  wire logic                     linActivity,
  input  wire logic                     senseIn1,
  input  wire logic                     inputWakeEnable,
  output logic                          failIndicator_b,
  output logic                          resetOut_b,
  output logic                          mcuSupplyOn,
  output fss_pkg::fss_variant_type      activeVariant,
  output logic                          persistentWdFail,
  output logic                          resumeReset
);
  import fss_pkg::*;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  fss_state_type   state_q;
  fss_state_type   state_d;
  fss_variant_type strapVar_q;
  fss_variant_type ovrVar_q;
  fss_variant_type variant_q;
  fss_variant_type variant_d;
  fss_variant_type strapDecode;
  logic            ovrValid_q;
  logic            failInd_q;
  logic            flagsCleared_q;
  logic            refreshSeen_q;
  logic            wakeArmed_q;
  logic            lowSeen_q;
  logic            senseIn1_q;
  logic            pulseActive_q;
  logic            resume_q;
  logic [3:0]      missCnt_q;
  logic [3:0]      missCnt_d;
  logic            wdExpired;
  logic            pulseDone;
  logic            idleExpired;
  logic            clampExpired;
  logic            wdFailEvent;
  logic            failEvent;
  logic            releaseCmd;
  logic            recovered;
  logic            cutCondition;
  logic            wakeEvent;
  logic            inFailOn;
  logic            inFailOff;
  logic            senseFall;

  // Resistor class decode of the strap measurement in kilohm.
  assign strapDecode = (strapResistorPin < STRAP_STAY_MAX_K)  ? STAY_POWERED :    // RULE5
                       (strapResistorPin < STRAP_IDLE_MAX_K)  ? IDLE_CUTOFF :
                       (strapResistorPin < STRAP_INPUT_MAX_K) ? INPUT_CUTOFF :
                       COMBINED_CUTOFF;

  // The override code 1xx maps its low bits inverted onto the variant.
  assign variant_d = ovrValid_q ? ovrVar_q : strapVar_q;                          // RULE4

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strapVar_q <= STAY_POWERED;
      ovrVar_q   <= STAY_POWERED;
      ovrValid_q <= 1'b0;
      variant_q  <= STAY_POWERED;
    end else begin
      if (initToNormal) begin
        strapVar_q <= strapDecode;                                                // RULE3
      end
      if (spiVariantWrite && spiVariantCode[OVR_VALID_BIT]) begin
        ovrVar_q   <= fss_variant_type'(~spiVariantCode[1:0]);                    // RULE4
        ovrValid_q <= 1'b1;
      end
      variant_q <= variant_d;
    end
  end

  assign activeVariant = variant_q;

  // Watchdog window, reset pulse, idle and clamp timers.
  fss_timer #(.CYCLES(WD_CYC)) u_wdWindow (
    .clock   (clock),
    .rst_b   (rst_b),
    .run     (mcuSupplyOn && !pulseActive_q),
    .restart (wdRefreshOk || wdExpired),
    .expired (wdExpired)
  );

  fss_timer #(.CYCLES(PULSE_CYC)) u_rstPulse (
    .clock   (clock),
    .rst_b   (rst_b),
    .run     (pulseActive_q),
    .restart (1'b0),
    .expired (pulseDone)
  );

  fss_timer #(.CYCLES(IDLE_CY)) u_idle (
    .clock   (clock),
    .rst_b   (rst_b),
    .run     (inFailOn),
    .restart (canActivity),                                                       // RULE18
    .expired (idleExpired)
  );

  fss_timer #(.CYCLES(CLAMP_CY)) u_clamp (
    .clock   (clock),
    .rst_b   (rst_b),
    .run     (resetPinLow && resetOut_b),
    .restart (1'b0),
    .expired (clampExpired)                                                       // RULE17
  );

  // Consecutive missed windows, cleared by a good refresh.
  assign missCnt_d = wdRefreshOk ? 4'h0 :
                     (wdExpired && missCnt_q != WD_FAIL_LIMIT) ? missCnt_q + 4'h1 :
                     missCnt_q;                                                   // RULE13
  assign persistentWdFail = missCnt_q == WD_FAIL_LIMIT;                           // RULE13
  assign wdFailEvent = wdExpired && (missCnt_q == {3'h0, wdSecondPulseSel});      // RULE15

  assign failEvent  = wdFailEvent || supplyLow || clampExpired;                   // RULE17
  assign releaseCmd = spiCmdValid && (spiCmd == REL_CMD_A || spiCmd == REL_CMD_B);
  assign recovered  = refreshSeen_q && !supplyLow && !resetPinLow;                // RULE12
  assign inFailOn   = state_q == ST_FAIL_ON;
  assign inFailOff  = state_q == ST_FAIL_OFF;
  assign senseFall  = senseIn1_q && !senseIn1;
  assign wakeEvent  = canActivity || linActivity || (wakeArmed_q && senseIn1);    // RULE10

  always_comb begin
    case (variant_q)
      IDLE_CUTOFF:     cutCondition = idleExpired;                                // RULE6
      INPUT_CUTOFF:    cutCondition = lowSeen_q && !senseIn1;                     // RULE7
      COMBINED_CUTOFF: cutCondition = idleExpired && lowSeen_q && !senseIn1;      // RULE8
      default:         cutCondition = 1'b0;                                       // RULE1
    endcase
  end

  always_comb begin
    case (state_q)
      ST_NORMAL: begin
        state_d = failEvent ? ST_FAIL_ON : ST_NORMAL;
      end
      ST_FAIL_ON: begin
        state_d = recovered ? ST_NORMAL :
                  cutCondition ? ST_FAIL_OFF : ST_FAIL_ON;                        // RULE2
      end
      ST_FAIL_OFF: begin
        state_d = wakeEvent ? ST_NORMAL : ST_FAIL_OFF;                            // RULE9
      end
      default: begin
        state_d = ST_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q       <= ST_NORMAL;
      missCnt_q     <= 4'h0;
      pulseActive_q <= 1'b0;
      resume_q      <= 1'b0;
      senseIn1_q    <= 1'b0;
    end else begin
      state_q       <= state_d;
      missCnt_q     <= missCnt_d;
      pulseActive_q <= wdExpired || (inFailOff && wakeEvent) ||
                       (pulseActive_q && !pulseDone);                             // RULE14
      resume_q      <= inFailOff && wakeEvent;                                    // RULE9
      senseIn1_q    <= senseIn1;
    end
  end

  // Failure bookkeeping; a new failure wins over a release or clear.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      failInd_q      <= 1'b0;
      flagsCleared_q <= 1'b0;
      refreshSeen_q  <= 1'b0;
      wakeArmed_q    <= 1'b0;
      lowSeen_q      <= 1'b0;
    end else begin
      if (failEvent) begin
        failInd_q <= 1'b1;
      end else if (releaseCmd && flagsCleared_q) begin
        failInd_q <= 1'b0;                                                        // RULE11
      end
      if (failEvent) begin
        flagsCleared_q <= 1'b0;
      end else if (mcuFlagsCleared) begin
        flagsCleared_q <= 1'b1;
      end
      if (state_q == ST_NORMAL && failEvent) begin
        refreshSeen_q <= 1'b0;
        wakeArmed_q   <= inputWakeEnable;                                         // RULE9
      end else if (wdRefreshOk) begin
        refreshSeen_q <= 1'b1;                                                    // RULE12
      end
      if (!inFailOn || senseIn1) begin
        lowSeen_q <= 1'b0;
      end else if (senseFall) begin
        lowSeen_q <= 1'b1;                                                        // RULE7
      end
    end
  end

  assign resetOut_b      = !(supplyLow || pulseActive_q);                         // RULE16
  assign failIndicator_b = !(failInd_q || supplyLow);                             // RULE16
  assign mcuSupplyOn     = !inFailOff;                                            // RULE1
  assign resumeReset     = resume_q;

  sequence s_wakeInOff;
    inFailOff && wakeEvent;
  endsequence
  sequence s_resumed;
    state_q == ST_NORMAL && resumeReset && !resetOut_b;
  endsequence

  property p_stayOn;
    variant_q == STAY_POWERED && inFailOn |=> mcuSupplyOn;
  endproperty
  a_stayOn: assert property (p_stayOn) else $error("supply cut in stay variant"); // RULE1

  property p_cutIdle;
    inFailOn && !recovered && variant_q == IDLE_CUTOFF && idleExpired |=> inFailOff;
  endproperty
  a_cutIdle: assert property (p_cutIdle) else $error("idle cut-off missed"); // RULE6

  property p_cutInput;
    inFailOn && !recovered && variant_q == INPUT_CUTOFF && lowSeen_q && !senseIn1
      |=> !mcuSupplyOn;
  endproperty
  a_cutInput: assert property (p_cutInput) else $error("input cut-off missed"); // RULE7

  property p_combined;
    $rose(inFailOff) && variant_q == COMBINED_CUTOFF |-> $past(idleExpired && lowSeen_q);
  endproperty
  a_combined: assert property (p_combined) else $error("combined cut too early"); // RULE8

  property p_override;
    spiVariantWrite && spiVariantCode[2] |=> ##1 activeVariant == ~$past(spiVariantCode[1:0], 2);
  endproperty
  a_override: assert property (p_override) else $error("override not applied"); // RULE4

  property p_strap;
    initToNormal && !ovrValid_q && !spiVariantWrite
      |=> ##1 activeVariant == $past(strapDecode, 2);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not applied"); // RULE3

  property p_supplyLow;
    supplyLow |-> !failIndicator_b && !resetOut_b;
  endproperty
  a_supplyLow: assert property (p_supplyLow) else $error("indicator not with reset"); // RULE16

  property p_wake;
    s_wakeInOff |=> s_resumed;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not resume"); // RULE9

  property p_release;
    failInd_q && !failEvent && releaseCmd && flagsCleared_q |=> failIndicator_b || supplyLow;
  endproperty
  a_release: assert property (p_release) else $error("release ignored"); // RULE11

  property p_holdInd;
    failInd_q && !(releaseCmd && flagsCleared_q) |=> !failIndicator_b;
  endproperty
  a_holdInd: assert property (p_holdInd) else $error("indicator dropped early"); // RULE11

  property p_wdPulse;
    wdExpired |=> !resetOut_b [*2];
  endproperty
  a_wdPulse: assert property (p_wdPulse) else $error("no reset pulse"); // RULE14

  property p_persist;
    wdExpired && missCnt_q == 4'h7 && !wdRefreshOk |=> persistentWdFail;
  endproperty
  a_persist: assert property (p_persist) else $error("persistent fail missed"); // RULE13

  property p_wdFail;
    state_q == ST_NORMAL && wdExpired && missCnt_q == {3'h0, wdSecondPulseSel}
      |=> !failIndicator_b && inFailOn;
  endproperty
  a_wdFail: assert property (p_wdFail) else $error("watchdog fail missed"); // RULE15
endmodule : fss_supervisor
`default_nettype wire

// ==== verif/fss_mcu_model.sv ====
// Host microcontroller model: watchdog refresh, flag clear and command words.
`default_nettype none
module fss_mcu_model #(
  parameter int REFRESH_CYC = 20
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        refreshOn,
  input  wire logic        flagReq,
  input  wire logic        cmdReq,
  input  wire logic [15:0] cmdWord,
  output logic             wdRefreshOk,
  output logic             mcuFlagsCleared,
  output logic             spiCmdValid,
  output logic [15:0]      spiCmd
);
  timeunit 1ns;
  timeprecision 1ns;
  int refreshCnt_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      refreshCnt_q    <= 0;
      wdRefreshOk     <= 1'b0;
      mcuFlagsCleared <= 1'b0;
      spiCmdValid     <= 1'b0;
      spiCmd          <= 16'h0000;
    end else begin
      refreshCnt_q    <= (refreshCnt_q == REFRESH_CYC - 1) ? 0 : refreshCnt_q + 1;
      wdRefreshOk     <= refreshOn && (refreshCnt_q == 0);
      mcuFlagsCleared <= flagReq;
      spiCmdValid     <= cmdReq;
      spiCmd          <= cmdReq ? cmdWord : ~spiCmd;
    end
  end
endmodule : fss_mcu_model
`default_nettype wire

// ==== verif/fail_state_supply_supervisor_tb_top.sv ====
// Self-checking testbench of the fail-state supervisor.
`default_nettype none
module fail_state_supply_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fss_pkg::*;
  localparam int WD  = 40;
  localparam int PL  = 4;
  localparam int IDL = 30;
  localparam int CLP = 5;
  logic            clock = 1'b0, rst_b = 1'b0, refreshOn = 1'b1, wdSel = 1'b0;
  logic            spiVariantWrite = 1'b0, senseIn1 = 1'b1, inputWakeEnable = 1'b0;
  logic [2:0]      spiVariantCode = 3'h0;
  logic [7:0]      strap = 8'h00;
  logic [6:0]      strobe = 7'h00;
  logic [15:0]     cmdWord = 16'h0000;
  logic            wdRefreshOk, mcuFlagsCleared, spiCmdValid;
  logic [15:0]     spiCmd;
  logic            failIndicator_b, resetOut_b, mcuSupplyOn, persistentWdFail, resumeReset;
  fss_variant_type activeVariant;
  int              n_mismatch = 0, checks_done = 0, n;
  logic [7:0]      straps [4] = '{8'h05, 8'h0F, 8'h21, 8'h44};

  always #50 clock = ~clock;

  fss_mcu_model mcu (.clock(clock), .rst_b(rst_b), .refreshOn(refreshOn), .flagReq(strobe[4]),
    .cmdReq(strobe[6]), .cmdWord(cmdWord), .wdRefreshOk(wdRefreshOk),
    .mcuFlagsCleared(mcuFlagsCleared), .spiCmdValid(spiCmdValid), .spiCmd(spiCmd));

  fss_supervisor #(.WD_CYC(WD), .PULSE_CYC(PL), .IDLE_CY(IDL), .CLAMP_CY(CLP)) dut (
    .clock(clock), .rst_b(rst_b), .strapResistorPin(strap), .initToNormal(strobe[3]),
    .spiVariantWrite(spiVariantWrite), .spiVariantCode(spiVariantCode),
    .spiCmdValid(spiCmdValid), .spiCmd(spiCmd), .mcuFlagsCleared(mcuFlagsCleared),
    .wdRefreshOk(wdRefreshOk), .wdSecondPulseSel(wdSel), .supplyLow(strobe[0]),
    .resetPinLow(strobe[5]), .canActivity(strobe[1]), .linActivity(strobe[2]),
    .senseIn1(senseIn1), .inputWakeEnable(inputWakeEnable),
    .failIndicator_b(failIndicator_b), .resetOut_b(resetOut_b), .mcuSupplyOn(mcuSupplyOn),
    .activeVariant(activeVariant), .persistentWdFail(persistentWdFail),
    .resumeReset(resumeReset));

  task automatic finish_test();
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : cyc

  task automatic wait_val(input int sel, input logic v, input int lim);
    logic s;
    #1;
    for (int i = 0; i <= lim; i++) begin
      s = (sel == 0) ? resetOut_b : (sel == 1) ? mcuSupplyOn : persistentWdFail;
      if (s === v) return;
      cyc(1);
    end
    n_mismatch++;
    $display("MISMATCH at %0t: wait got %0h expected %0h", $time, s, v);
    finish_test();
  endtask : wait_val

  task automatic hold(input int sel, input int k);
    @(posedge clock);
    strobe[sel] <= 1'b1;
    repeat (k) @(posedge clock);
    strobe[sel] <= 1'b0;
    #1;
  endtask : hold

  task automatic set_var(input logic [2:0] code);
    @(posedge clock);
    spiVariantWrite <= 1'b1;
    spiVariantCode  <= code;
    @(posedge clock);
    spiVariantWrite <= 1'b0;
    cyc(3);
  endtask : set_var

  task automatic send(input logic [15:0] w);
    @(posedge clock);
    cmdWord   <= w;
    strobe[6] <= 1'b1;
    @(posedge clock);
    strobe[6] <= 1'b0;
    cyc(3);
  endtask : send

  task automatic do_reset();
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    cyc(2);
  endtask : do_reset

  initial begin
    do_reset();
    chk(activeVariant, 16'h0);
    chk(mcuSupplyOn, 16'h1);
    chk(failIndicator_b, 16'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      strap <= straps[i];
      hold(3, 1);
      cyc(3);
      chk(activeVariant, 16'(i));
    end
    for (int i = 0; i < 4; i++) begin
      set_var(3'h7 - i[2:0]);
      chk(activeVariant, 16'(i));
    end
    set_var(3'h2);
    @(posedge clock);
    strap <= 8'h05;
    hold(3, 1);
    cyc(3);
    chk(activeVariant, 16'h3);
    do_reset();
    @(posedge clock);
    strobe[0] <= 1'b1;
    #1;
    chk(failIndicator_b, 16'h0);
    chk(resetOut_b, 16'h0);
    hold(0, 1);
    cyc(5);
    chk(mcuSupplyOn, 16'h1);
    send(REL_CMD_A);
    chk(failIndicator_b, 16'h0);
    hold(4, 1);
    cyc(2);
    send(REL_CMD_B);
    chk(failIndicator_b, 16'h1);
    for (int s = 0; s < 2; s++) begin
      @(posedge clock);
      refreshOn <= 1'b0;
      wdSel     <= s[0];
      do_reset();
      for (int k = 1; k <= 8; k++) begin
        wait_val(0, 1'b0, 15 + ((k == 1) ? WD : 0));
        if (k == 1) chk(failIndicator_b, s[0]);
        if (k == 2) chk(failIndicator_b, 16'h0);
        n = 0;
        while (resetOut_b === 1'b0 && n < 20) begin
          cyc(1);
          n++;
        end
        chk(16'(n), 16'(PL + 1));
        chk(persistentWdFail, k == 8);
        cyc(WD - 5);
        chk(resetOut_b, 16'h1);
      end
      chk(mcuSupplyOn, 16'h1);
    end
    @(posedge clock);
    refreshOn <= 1'b1;
    do_reset();
    set_var(3'h6);
    hold(0, 1);
    cyc(IDL + 15);
    chk(mcuSupplyOn, 16'h1);
    do_reset();
    set_var(3'h6);
    @(posedge clock);
    refreshOn <= 1'b0;
    hold(0, 1);
    cyc(20);
    hold(1, 1);
    cyc(IDL - 8);
    chk(mcuSupplyOn, 16'h1);
    wait_val(1, 1'b0, 20);
    hold(1, 1);
    chk(mcuSupplyOn, 16'h1);
    chk(resumeReset, 16'h1);
    do_reset();
    set_var(3'h5);
    @(posedge clock);
    inputWakeEnable <= 1'b1;
    wait_val(0, 1'b0, WD + 25);
    wait_val(0, 1'b1, 10);
    chk(failIndicator_b, 16'h1);
    hold(5, CLP - 2);
    chk(failIndicator_b, 16'h1);
    hold(5, CLP + 3);
    chk(failIndicator_b, 16'h0);
    cyc(10);
    chk(mcuSupplyOn, 16'h1);
    @(posedge clock);
    senseIn1 <= 1'b0;
    wait_val(1, 1'b0, 5);
    @(posedge clock);
    senseIn1 <= 1'b1;
    wait_val(1, 1'b1, 3);
    do_reset();
    set_var(3'h4);
    @(posedge clock);
    inputWakeEnable <= 1'b0;
    hold(0, 1);
    @(posedge clock);
    senseIn1 <= 1'b0;
    cyc(IDL - 10);
    chk(mcuSupplyOn, 16'h1);
    wait_val(1, 1'b0, 20);
    @(posedge clock);
    senseIn1 <= 1'b1;
    cyc(10);
    chk(mcuSupplyOn, 16'h0);
    hold(2, 1);
    chk(mcuSupplyOn, 16'h1);
    finish_test();
  end
endmodule : fail_state_supply_supervisor_tb_top
`default_nettype wire
